// ===== led_sink_pkg.sv
// Shared constants, types and layouts for the LED sink driver control
package led_sink_pkg;
   localparam int NUM_CH = 16;
   localparam int DC_BITS = 6;
   localparam int GS_BITS = 12;
   localparam int DC_LEN = 96;
   localparam int GS_LEN = 192;
   localparam int CLK_PERIOD_NS = 40;
   localparam int STAGGER_STEP_NS = 20;
   localparam int OPEN_DETECT_NS = 1000;
   localparam int SHORT_BLANK_NS = 300;
   localparam int OPEN_DETECT_CYCLES = (OPEN_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_BLANK_CYCLES = SHORT_BLANK_NS / CLK_PERIOD_NS;
   localparam int MAX_STAGGER = ((NUM_CH - 1) * STAGGER_STEP_NS) / CLK_PERIOD_NS;
   localparam int SID_OPEN_LSB = 0;
   localparam int SID_THERMAL_BIT = 16;
   localparam int SID_DC_LSB = 24;
   localparam logic [DC_BITS-1:0] NV_DEFAULT = 6'h3f;
   localparam logic [GS_BITS-1:0] GS_MAX = 12'hfff;
   localparam logic [15:0] OPEN_DELAY_RESET = 16'(OPEN_DETECT_CYCLES);
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] OPEN_DELAY_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] STATE_ADDR = 8'h08;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_GRAYSCALE = 2'b00,
      MODE_DOT_CORR = 2'b01,
      MODE_PROGRAM = 2'b10,
      MODE_RESERVED = 2'b11
   } mode_t;

   typedef enum logic [0:0] {
      PROG_IDLE = 1'b0,
      PROG_WRITE = 1'b1
   } prog_state_t;

   typedef struct packed {
      logic serial_clock;
      logic serial_in;
      logic latch_strobe;
      logic output_blanking;
      logic pwm_count_clock;
      logic [1:0] mode_select_input;
      logic dc_source_select;
      logic over_temp;
      logic [NUM_CH-1:0] led_voltage_low;
   } pin_in_t;
endpackage : led_sink_pkg

// ===== nv_store.sv
// Nonvolatile correction store, one word per channel, registered read
`timescale 1ns/1ns
`default_nettype none
module nv_store
   import led_sink_pkg::*;
#(
   parameter int WIDTH = DC_BITS,
   parameter int DEPTH = NUM_CH,
   parameter logic [WIDTH-1:0] INIT = NV_DEFAULT
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Unprogrammed cells read as all ones
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int k = 0; k < DEPTH; k++)
            mem[k] <= INIT;
         rd_data <= INIT;
      end
      else
      begin
         if (wr_en)
            mem[wr_addr] <= wr_data;
         rd_data <= mem[rd_addr];
      end
   end
endmodule : nv_store
`default_nettype wire

// ===== led_sink_ctrl.sv
// LED sink driver control: serial load, correction, blanking, stagger, error flags
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module led_sink_ctrl
   import led_sink_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic latch_strobe,
   input wire logic output_blanking,
   input wire logic pwm_count_clock,
   input wire logic [1:0] mode_select_input,
   input wire logic dc_source_select,
   input wire logic over_temp,
   input wire logic [NUM_CH-1:0] led_voltage_low,
   output logic serial_out,
   output logic [NUM_CH-1:0] channel_output,
   output logic error_out_n,
   output logic error_out_n_oe
);
   localparam int PIN_W = $bits(pin_in_t);

   logic [PIN_W-1:0] sync1, sync2;
   pin_in_t pin, pin_d;
   logic sclk_rise, latch_rise, latch_fall, blank_rise, pwm_count_clock_rise, dcsel_rise;
   mode_t mode;

   // Two-stage synchroniser for every outside pin
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= '0;
         sync2 <= '0;
         pin_d <= '0;
      end
      else
      begin
         sync1 <= {serial_clock, serial_in, latch_strobe, output_blanking, pwm_count_clock,
                   mode_select_input, dc_source_select, over_temp, led_voltage_low};
         sync2 <= sync1;
         pin_d <= pin;
      end
   end

   assign pin = pin_in_t'(sync2);
   assign mode = mode_t'(pin.mode_select_input);
   assign sclk_rise = pin.serial_clock & ~pin_d.serial_clock;
   assign latch_rise = pin.latch_strobe & ~pin_d.latch_strobe;
   assign latch_fall = ~pin.latch_strobe & pin_d.latch_strobe;
   assign blank_rise = pin.output_blanking & ~pin_d.output_blanking;
   assign pwm_count_clock_rise = pin.pwm_count_clock & ~pin_d.pwm_count_clock;
   assign dcsel_rise = pin.dc_source_select & ~pin_d.dc_source_select;

   // Serial path, latches and nonvolatile programming
   logic [GS_LEN-1:0] shift, next_shift, gs_latch, next_gs_latch, status_info_packet;
   logic [DC_LEN-1:0] dc_latch, next_dc_latch, nv_shadow, next_nv_shadow, dc_active;
   logic next_serial_out;
   prog_state_t prog_state, next_prog_state;
   logic [3:0] wr_idx, next_wr_idx, rd_idx, rd_prev;
   logic [DC_BITS-1:0] nv_rd_data;
   logic nv_wr_en;
   logic [NUM_CH-1:0] open_flag, next_open_flag;
   logic thermal_flag;
   logic [GS_BITS-1:0] gs_cnt, next_gs_cnt;

   assign dc_active = pin.dc_source_select ? dc_latch : nv_shadow;
   assign status_info_packet = {72'h0, dc_active, 7'h0, thermal_flag, open_flag};
   assign nv_wr_en = (prog_state == PROG_WRITE);

   always_comb
   begin
      next_shift = shift;
      next_gs_latch = gs_latch;
      next_dc_latch = dc_latch;
      next_nv_shadow = nv_shadow;
      next_prog_state = prog_state;
      next_wr_idx = wr_idx;
      // MSB first into the low end
      if (sclk_rise)
         next_shift = {shift[GS_LEN-2:0], pin.serial_in};
      if (latch_fall && mode == MODE_GRAYSCALE)
         next_shift = status_info_packet;
      if (latch_rise && mode == MODE_GRAYSCALE)
         next_gs_latch = shift;
      if (pin.latch_strobe && mode == MODE_DOT_CORR)
         next_dc_latch = shift[DC_LEN-1:0];
      if (mode == MODE_DOT_CORR)
         next_serial_out = next_shift[DC_LEN-1];
      else
         next_serial_out = next_shift[GS_LEN-1];
      next_nv_shadow[int'(rd_prev) * DC_BITS +: DC_BITS] = nv_rd_data;
      case (prog_state)
         PROG_IDLE:
         begin
            if (mode == MODE_PROGRAM && dcsel_rise)
            begin
               next_prog_state = PROG_WRITE;
               next_wr_idx = 4'h0;
            end
         end
         PROG_WRITE:
         begin
            next_wr_idx = wr_idx + 4'h1;
            if (wr_idx == 4'hf)
               next_prog_state = PROG_IDLE;
         end
         default: next_prog_state = PROG_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         shift <= '0;
         gs_latch <= '0;
         dc_latch <= '0;
         nv_shadow <= {NUM_CH{NV_DEFAULT}};
         serial_out <= 1'b0;
         prog_state <= PROG_IDLE;
         wr_idx <= 4'h0;
         rd_idx <= 4'h0;
         rd_prev <= 4'h0;
      end
      else
      begin
         shift <= next_shift;
         gs_latch <= next_gs_latch;
         dc_latch <= next_dc_latch;
         nv_shadow <= next_nv_shadow;
         serial_out <= next_serial_out;
         prog_state <= next_prog_state;
         wr_idx <= next_wr_idx;
         rd_idx <= rd_idx + 4'h1;
         rd_prev <= rd_idx;
      end
   end

   nv_store u_nv_store (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(nv_wr_en),
      .wr_addr(wr_idx),
      .wr_data(dc_latch[int'(wr_idx) * DC_BITS +: DC_BITS]),
      .rd_addr(rd_idx),
      .rd_data(nv_rd_data)
   );

   // Grayscale counter, short blank stretch and stagger history
   logic [3:0] low_len, next_low_len, short_timer, next_short_timer;
   logic [NUM_CH-1:0] short_mask, next_short_mask, raw_on, gs_nonzero;
   logic [MAX_STAGGER:0][NUM_CH-1:0] hist;
   logic short_active, out_en;
   logic [15:0] open_delay, next_open_delay;

   assign short_active = (short_timer != 4'h0);
   assign out_en = ~pin.output_blanking | short_active;

   always_comb
   begin
      next_gs_cnt = gs_cnt;
      next_low_len = low_len;
      next_short_timer = short_timer;
      next_short_mask = short_mask;
      if (pin.output_blanking)
         next_gs_cnt = '0;
      else if (pwm_count_clock_rise && gs_cnt != GS_MAX)
         next_gs_cnt = gs_cnt + 12'h001;
      if (pin.output_blanking)
         next_low_len = 4'h0;
      else if (low_len < 4'(SHORT_BLANK_CYCLES))
         next_low_len = low_len + 4'h1;
      if (short_active)
         next_short_timer = short_timer - 4'h1;
      // keep lit for the low duration
      if (blank_rise && low_len < 4'(SHORT_BLANK_CYCLES))
      begin
         next_short_timer = low_len;
         next_short_mask = gs_nonzero;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gs_cnt <= '0;
         low_len <= 4'h0;
         short_timer <= 4'h0;
         short_mask <= '0;
         hist <= '0;
         thermal_flag <= 1'b0;
         open_flag <= '0;
         error_out_n <= 1'b0;
         error_out_n_oe <= 1'b0;
      end
      else
      begin
         gs_cnt <= next_gs_cnt;
         low_len <= next_low_len;
         short_timer <= next_short_timer;
         short_mask <= next_short_mask;
         hist <= {hist[MAX_STAGGER-1:0], raw_on};
         thermal_flag <= pin.over_temp;
         open_flag <= next_open_flag;
         error_out_n <= 1'b0;
         error_out_n_oe <= (|next_open_flag) | pin.over_temp;
      end
   end

   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++)
      begin : g_ch
         localparam int DELAY = (i * STAGGER_STEP_NS) / CLK_PERIOD_NS;
         logic [GS_BITS-1:0] gs_val;
         logic [15:0] on_time, next_on_time;
         logic next_out;

         assign gs_val = gs_latch[i * GS_BITS +: GS_BITS];
         assign gs_nonzero[i] = (gs_val != '0);
         assign raw_on[i] = (~pin.output_blanking & (gs_cnt != '0) & (gs_cnt <= gs_val)
                             & (gs_cnt != GS_MAX)) | (short_active & short_mask[i]);

         always_comb
         begin
            next_out = hist[DELAY][i];
            if (!channel_output[i])
               next_on_time = 16'h0;
            else if (on_time < open_delay)
               next_on_time = on_time + 16'h1;
            else
               next_on_time = on_time;
            // only when on, settled and low
            next_open_flag[i] = channel_output[i] & out_en & (on_time >= open_delay)
                                & pin.led_voltage_low[i];
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               channel_output[i] <= 1'b0;
               on_time <= 16'h0;
            end
            else
            begin
               channel_output[i] <= next_out;
               on_time <= next_on_time;
            end
         end
      end
   endgenerate

   // Register bus slave
   logic aw_have, next_aw_have, w_have, next_w_have;
   logic [ADDR_W-1:0] aw_q, next_aw_q;
   logic [31:0] w_q, next_w_q, next_rdata;
   logic [3:0] strb_q, next_strb_q;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;

   always_comb
   begin
      next_aw_have = aw_have;
      next_w_have = w_have;
      next_aw_q = aw_q;
      next_w_q = w_q;
      next_strb_q = strb_q;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_open_delay = open_delay;
      if (awvalid && awready)
      begin
         next_aw_have = 1'b1;
         next_aw_q = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_have = 1'b1;
         next_w_q = wdata;
         next_strb_q = wstrb;
      end
      if (bvalid && bready)
         next_bvalid = 1'b0;
      if (aw_have && w_have && !bvalid)
      begin
         next_aw_have = 1'b0;
         next_w_have = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = AXI_OKAY;
         if (aw_q == OPEN_DELAY_ADDR)
         begin
            if (strb_q[0])
               next_open_delay[7:0] = w_q[7:0];
            if (strb_q[1])
               next_open_delay[15:8] = w_q[15:8];
         end
         else if (aw_q != STATUS_ADDR && aw_q != STATE_ADDR)
            next_bresp = AXI_SLVERR;
      end
      if (rvalid && rready)
         next_rvalid = 1'b0;
      if (arvalid && arready)
      begin
         next_rvalid = 1'b1;
         next_rresp = AXI_OKAY;
         case (araddr)
            STATUS_ADDR: next_rdata = {15'h0, thermal_flag, open_flag};
            OPEN_DELAY_ADDR: next_rdata = {16'h0, open_delay};
            STATE_ADDR: next_rdata = {14'h0, pin.dc_source_select, nv_wr_en, mode, 2'h0, gs_cnt};
            default:
            begin
               next_rdata = 32'h0;
               next_rresp = AXI_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_q <= '0;
         w_q <= 32'h0;
         strb_q <= 4'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= AXI_OKAY;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= AXI_OKAY;
         rdata <= 32'h0;
         open_delay <= OPEN_DELAY_RESET;
      end
      else
      begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         aw_q <= next_aw_q;
         w_q <= next_w_q;
         strb_q <= next_strb_q;
         awready <= ~next_aw_have;
         wready <= ~next_w_have;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         arready <= ~next_rvalid;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         open_delay <= next_open_delay;
      end
   end
endmodule : led_sink_ctrl
`default_nettype wire

// ===== led_sink_properties.sv
// Port checks for the LED sink control
`timescale 1ns/1ns
`default_nettype none
module led_sink_properties
   import led_sink_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic over_temp,
   input wire logic output_blanking,
   input wire logic [NUM_CH-1:0] led_voltage_low,
   input wire logic [NUM_CH-1:0] channel_output,
   input wire logic error_out_n,
   input wire logic error_out_n_oe,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic bvalid,
   input wire logic bready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [5:0] blank_cnt;
   logic [5:0] next_blank_cnt;
   logic [3:0] hot_cnt;
   logic [3:0] next_hot_cnt;
   logic [3:0] calm_cnt;
   logic [3:0] next_calm_cnt;

   // Saturating run lengths
   always_comb
   begin
      next_blank_cnt = output_blanking ? blank_cnt + 6'(blank_cnt != 6'h3f) : 6'h00;
      next_hot_cnt = over_temp ? hot_cnt + 4'(hot_cnt != 4'hf) : 4'h0;
      next_calm_cnt = (over_temp || led_voltage_low != '0) ? 4'h0 : calm_cnt + 4'(calm_cnt != 4'hf);
      if (!aresetn)
      begin
         next_blank_cnt = 6'h00;
         next_hot_cnt = 4'h0;
         next_calm_cnt = 4'h0;
      end
   end

   always_ff @(posedge aclk)
   begin
      blank_cnt <= next_blank_cnt;
      hot_cnt <= next_hot_cnt;
      calm_cnt <= next_calm_cnt;
   end

   chk_hot_pulls_low: assert property (hot_cnt >= 4'h6 |-> error_out_n_oe)
      else $error("error line idle while hot");
   chk_quiet_releases: assert property (calm_cnt >= 4'h6 |-> !error_out_n_oe)
      else $error("error line pulled without cause");
   chk_drain_low: assert property (error_out_n_oe |-> error_out_n == 1'b0)
      else $error("error line driven high");
   chk_blank_off: assert property (blank_cnt >= 6'd20 |-> channel_output == '0)
      else $error("channel on while blanked");
   chk_blank_masks_open: assert property ((blank_cnt >= 6'd20 && !over_temp)[*5] |-> !error_out_n_oe)
      else $error("open flag while blanked");
   chk_read_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed early");
   chk_read_blocks: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   chk_write_holds: assert property (bvalid && !bready |=> bvalid)
      else $error("write answer dropped early");

   cov_error: cover property ($rose(error_out_n_oe));
   cov_blank: cover property (blank_cnt == 6'd20);
   cov_last_off: cover property ($fell(channel_output[15]));
endmodule : led_sink_properties

bind led_sink_ctrl led_sink_properties i_props (.aclk, .aresetn, .over_temp, .output_blanking,
   .led_voltage_low, .channel_output, .error_out_n, .error_out_n_oe, .arready, .rvalid, .rready,
   .rdata, .rresp, .bvalid, .bready);
`default_nettype wire

// ===== led_host_model.sv
// Host model: serial shift, readout and latch strobe
`timescale 1ns/1ns
`default_nettype none
module led_host_model
(
   input wire logic serial_out,
   output logic serial_clock,
   output logic serial_in,
   output logic latch_strobe
);
   initial
   begin
      serial_clock = 1'b0;
      serial_in = 1'b0;
      latch_strobe = 1'b0;
   end

   task automatic xfer(input logic [192:0] d, input int n, output logic [192:0] q);
      q = '0;
      #13;
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_in <= d[i];
         #160;
         q[i] = serial_out;
         serial_clock <= 1'b1;
         #160;
         serial_clock <= 1'b0;
      end
      #160;
      serial_in <= ~serial_in;
      #160;
   endtask : xfer

   task automatic latch;
      latch_strobe <= 1'b1;
      #320;
      latch_strobe <= 1'b0;
      #320;
   endtask : latch
endmodule : led_host_model
`default_nettype wire

// ===== led_sink_driver_control_test.sv
// Self-checking bench for the LED sink control
`timescale 1ns/1ns
`default_nettype none
module led_sink_driver_control_test
   import led_sink_pkg::*;
;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, serial_clock, serial_in, latch_strobe;
   logic serial_out, output_blanking, pwm_count_clock, dc_source_select, over_temp;
   logic error_out_n, error_out_n_oe;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, lfsr;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, mode_select_input;
   logic [NUM_CH-1:0] led_voltage_low, channel_output, prev_ch;
   logic [192:0] gcur;
   int miscompares, checks_done, cyc;
   int t_on[NUM_CH];
   int t_off[NUM_CH];

   led_sink_ctrl i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .serial_clock, .serial_in, .latch_strobe, .output_blanking, .pwm_count_clock,
      .mode_select_input, .dc_source_select, .over_temp, .led_voltage_low, .serial_out,
      .channel_output, .error_out_n, .error_out_n_oe);
   led_host_model i_host (.serial_out, .serial_clock, .serial_in, .latch_strobe);

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // Edge times of every channel
   always @(posedge aclk)
   begin
      for (int n = 0; n < NUM_CH; n++)
      begin
         if (channel_output[n] === 1'b1 && prev_ch[n] !== 1'b1) t_on[n] = cyc;
         if (channel_output[n] === 1'b0 && prev_ch[n] === 1'b1) t_off[n] = cyc;
      end
      prev_ch = channel_output;
      cyc = cyc + 1;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   function automatic logic [192:0] gs_pkt(input logic [11:0] g, input int zero_ch);
      logic [192:0] p;
      p = '0;
      for (int n = 0; n < NUM_CH; n++)
         p[12*n +: 12] = (n == zero_ch) ? 12'h000 : g;
      return p;
   endfunction : gs_pkt

   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 200);
      r = bresp;
      bready <= 1'b0;
      if (n >= 200) miscompares++;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 200) miscompares++;
   endtask : axi_rd

   // Latch current conditions, then shift them out
   task automatic rdback(output logic [192:0] q);
      i_host.xfer(gcur, 192, q);
      i_host.latch();
      i_host.xfer(gcur, 192, q);
      i_host.latch();
   endtask : rdback

   task automatic pwm_steps(input int k);
      repeat (k)
      begin
         repeat (4) @(posedge aclk);
         pwm_count_clock <= 1'b1;
         repeat (4) @(posedge aclk);
         pwm_count_clock <= 1'b0;
      end
   endtask : pwm_steps

   initial
   begin
      #3000000;
      miscompares++;
      end_sim();
   end

   initial
   begin
      logic [192:0] q;
      logic [95:0] dc;
      logic [31:0] d;
      logic [1:0] r;
      int g;
      {miscompares, checks_done, cyc, lfsr, gcur} = '0;
      lfsr = 32'hd7f2;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      {pwm_count_clock, mode_select_input, dc_source_select, over_temp, led_voltage_low} = '0;
      output_blanking = 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(OPEN_DELAY_ADDR, d, r);
      chk(d[15:0], OPEN_DELAY_RESET);
      axi_wr(OPEN_DELAY_ADDR, 32'h0000ff02, 4'h1, r);
      axi_rd(OPEN_DELAY_ADDR, d, r);
      chk(d[15:0], 16'h0002);
      axi_wr(8'h0c, 32'h0, 4'hf, r);
      chk(r, AXI_SLVERR);
      axi_rd(8'h0c, d, r);
      chk({d, r}, {32'h0, AXI_SLVERR});
      $display("test registers done");
      i_host.xfer('0, 193, q);
      i_host.latch();
      i_host.xfer(gcur, 192, q);
      chk(q[119:24], {NUM_CH{NV_DEFAULT}});
      chk(q[16:0], 17'h0);
      for (int k = 0; k < 3; k++)
      begin
         lfsr = lfsr_next(lfsr);
         dc[32*k +: 32] = lfsr;
      end
      @(posedge aclk);
      mode_select_input <= 2'b01;
      output_blanking <= 1'b0;
      i_host.xfer({97'h0, dc}, 96, q);
      i_host.latch();
      i_host.xfer({97'h0, ~dc}, 96, q);
      @(posedge aclk);
      mode_select_input <= 2'b00;
      dc_source_select <= 1'b1;
      output_blanking <= 1'b1;
      rdback(q);
      chk(q[119:24], dc);
      @(posedge aclk);
      dc_source_select <= 1'b0;
      mode_select_input <= 2'b10;
      repeat (4) @(posedge aclk);
      dc_source_select <= 1'b1;
      g = 0;
      do
      begin
         axi_rd(STATE_ADDR, d, r);
         g++;
      end
      while ((d[16] === 1'b1 || g < 4) && g < 50);
      @(posedge aclk);
      mode_select_input <= 2'b00;
      dc_source_select <= 1'b0;
      rdback(q);
      chk(q[119:24], dc);
      $display("test correction done");
      lfsr = lfsr_next(lfsr);
      gcur = gs_pkt({8'h00, lfsr[3:0] | 4'h1}, NUM_CH);
      i_host.xfer(gcur, 192, q);
      i_host.latch();
      @(posedge aclk);
      output_blanking <= 1'b0;
      pwm_steps(20);
      repeat (20) @(posedge aclk);
      for (int n = 0; n < NUM_CH; n++)
      begin
         chk(t_on[n] - t_on[0], n * STAGGER_STEP_NS / CLK_PERIOD_NS);
         chk(t_off[n] - t_off[0], n * STAGGER_STEP_NS / CLK_PERIOD_NS);
      end
      axi_rd(STATE_ADDR, d, r);
      chk(d[11:0], 12'd20);
      @(posedge aclk);
      output_blanking <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_rd(STATE_ADDR, d, r);
      chk(d[11:0], 12'h000);
      $display("test stagger done");
      gcur = gs_pkt(12'h800, 9);
      i_host.xfer(gcur, 192, q);
      i_host.latch();
      @(posedge aclk);
      led_voltage_low <= 16'h0220;
      output_blanking <= 1'b0;
      pwm_steps(1);
      repeat (40) @(posedge aclk);
      chk(error_out_n_oe, 1'b1);
      axi_rd(STATUS_ADDR, d, r);
      chk(d[16:0], 17'h00020);
      @(posedge aclk);
      over_temp <= 1'b1;
      rdback(q);
      chk(q[16:0], 17'h10020);
      @(posedge aclk);
      over_temp <= 1'b0;
      led_voltage_low <= '0;
      output_blanking <= 1'b1;
      repeat (10) @(posedge aclk);
      chk(error_out_n_oe, 1'b0);
      $display("test error flags done");
      output_blanking <= 1'b0;
      repeat (4) @(posedge aclk);
      output_blanking <= 1'b1;
      repeat (30) @(posedge aclk);
      chk(t_off[0] - t_on[0], 4);
      $display("test short blank done");
      end_sim();
   end
endmodule : led_sink_driver_control_test
`default_nettype wire
